//--- sdra_spi.v
// spi datagram slave with pipelined register read and status byte
// Summary of operation
// - frame is address byte plus 32 data bits
// - every register moves as full 32 bits
// - bit 39 selects write, low seven address
// - full 40-bit reply on every datagram
// - after read, reply carries addressed register
// - after write, reply echoes written word
// - read captures address only, no writes
// - reply top byte is the status byte
// - status latched at frame end, sent next
// - bit7 zero, bits6,5 left stop switches
// - bits4,3 velocity reached per axis
// - bits2,1 driver errors, cleared reading global_status_register
// - bit0 reset flag, cleared reading global_status_register
// - short values sit right aligned
// - signed twos complement, others plain binary
// - sample rising edge, shift falling, msb first
// - last 40 bits at cs rise, daisy delay
`timescale 1ns/10ps
`include "sdra_consts.vh"
module sdra_spi #(
  parameter FRAME_BITS = `SDRA_FRAME_BITS,
  parameter DATA_BITS  = `SDRA_DATA_BITS,
  parameter ADDR_BITS  = `SDRA_ADDR_BITS
) (
  input  wire                 clk,
  input  wire                 reset_n,
  input  wire                 clk_en,
  input  wire                 sck,
  input  wire                 sdi,
  input  wire                 chip_select_low,
  output reg                  sdo,
  input  wire [DATA_BITS-1:0] axis1_ramp_status,
  input  wire [DATA_BITS-1:0] axis2_ramp_status,
  input  wire [2:0]           global_status_register,
  input  wire [DATA_BITS-1:0] reg_rd_data,
  output reg  [ADDR_BITS-1:0] reg_addr,
  output reg  [DATA_BITS-1:0] reg_wr_data,
  output reg                  reg_wr_stb,
  output reg                  reg_rd_stb,
  output reg                  global_status_register_clr_stb
);
  // ************************************************************
  // reset release and input synchronisers
  // ************************************************************
  reg [1:0] rst_sync_r;
  wire      rst_n = rst_sync_r[1];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  reg [1:0] sck_s1_r;
  reg [1:0] sck_s2_r;
  reg       sck_d_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s1_r <= 2'h3;
      sck_s2_r <= 2'h3;
      sck_d_r  <= 1'b1;
    end else if (clk_en) begin
      // bit0 sck, bit1 chip select; stage one read only by stage two
      sck_s1_r <= {chip_select_low, sck};
      sck_s2_r <= sck_s1_r;
      sck_d_r  <= sck_s2_r[0];
    end
  end
  reg       sdi_s1_r;
  reg       sdi_s2_r;
  reg       cs_d_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else if (clk_en) begin
      sdi_s1_r <= sdi;
      sdi_s2_r <= sdi_s1_r;
      cs_d_r   <= sck_s2_r[1];
    end
  end

  wire sck_q   = sck_s2_r[0];
  wire cs_q    = sck_s2_r[1];
  wire sck_rise = sck_q & ~sck_d_r;
  wire sck_fall = ~sck_q & sck_d_r;
  wire cs_fall  = ~cs_q & cs_d_r;
  wire cs_rise  = cs_q & ~cs_d_r;
  wire active   = ~cs_q;

  // ************************************************************
  // status byte sources
  // ************************************************************
  wire [7:0] status_now;
  assign status_now[7] = 1'b0;
  assign status_now[`SDRA_ST_STOPL2]  = axis2_ramp_status[`SDRA_RAMP_STOPL_BIT];
  assign status_now[`SDRA_ST_STOPL1]  = axis1_ramp_status[`SDRA_RAMP_STOPL_BIT];
  assign status_now[`SDRA_ST_VREACH2] = axis2_ramp_status[`SDRA_RAMP_VREACH_BIT];
  assign status_now[`SDRA_ST_VREACH1] = axis1_ramp_status[`SDRA_RAMP_VREACH_BIT];
  assign status_now[`SDRA_ST_DRVERR2] = global_status_register[2];
  assign status_now[`SDRA_ST_DRVERR1] = global_status_register[1];
  assign status_now[`SDRA_ST_RESET]   = global_status_register[0];

  // ************************************************************
  // shift register, command decode, response loading
  // ************************************************************
  reg [FRAME_BITS-1:0] shift_r;
  reg [7:0]            status_r;
  reg [DATA_BITS-1:0]  resp_r;
  reg                  prev_rd_r;
  reg                  rd_pend_r;
  reg                  first_edge_r;

  wire                 cmd_wr   = shift_r[`SDRA_WSEL_BIT];
  wire [ADDR_BITS-1:0] cmd_addr = shift_r[`SDRA_WSEL_BIT-1:DATA_BITS];
  wire [DATA_BITS-1:0] cmd_data = shift_r[DATA_BITS-1:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r       <= {FRAME_BITS{1'b0}};
      status_r      <= 8'h00;
      resp_r        <= `SDRA_RESP_RESET;
      prev_rd_r     <= 1'b0;
      rd_pend_r     <= 1'b0;
      first_edge_r  <= 1'b0;
      sdo           <= 1'b0;
      reg_addr      <= {ADDR_BITS{1'b0}};
      reg_wr_data   <= {DATA_BITS{1'b0}};
      reg_wr_stb    <= 1'b0;
      reg_rd_stb    <= 1'b0;
      global_status_register_clr_stb <= 1'b0;
    end else if (clk_en) begin
      reg_wr_stb    <= 1'b0;
      reg_rd_stb    <= 1'b0;
      global_status_register_clr_stb <= 1'b0;
      if (rd_pend_r) begin
        // read data is taken in the same cycle as the strobe
        rd_pend_r <= 1'b0;
        resp_r    <= reg_rd_data;
      end
      if (cs_fall) begin
        // load reply: status top, data below, msb leads
        shift_r      <= {status_r, resp_r};
        sdo          <= status_r[7];
        first_edge_r <= 1'b1;
      end else if (active && sck_rise) begin
        shift_r <= {shift_r[FRAME_BITS-2:0], sdi_s2_r};
      end else if (active && sck_fall) begin
        // the first falling edge of mode 3 precedes any data bit
        if (first_edge_r) begin
          first_edge_r <= 1'b0;
        end else begin
          sdo <= shift_r[FRAME_BITS-1];
        end
      end else if (cs_rise) begin
        // only the last 40 bits held here count as the command
        status_r <= status_now;
        reg_addr <= cmd_addr;
        if (cmd_wr) begin
          reg_wr_data <= cmd_data;
          reg_wr_stb  <= 1'b1;
          resp_r      <= cmd_data;
          prev_rd_r   <= 1'b0;
        end else begin
          reg_rd_stb  <= 1'b1;
          rd_pend_r   <= 1'b1;
          prev_rd_r   <= 1'b1;
          if (cmd_addr == `SDRA_GLOBAL_STATUS_REGISTER_ADDR) begin
            global_status_register_clr_stb <= 1'b1;
          end
        end
      end
    end
  end
endmodule

//--- sdra_consts.vh
// constants for the serial datagram register access block
`ifndef SDRA_CONSTS_VH
`define SDRA_CONSTS_VH
`define SDRA_FRAME_BITS      40
`define SDRA_DATA_BITS       32
`define SDRA_ADDR_BITS       7
`define SDRA_WSEL_BIT        39
`define SDRA_STAT_HI         39
`define SDRA_STAT_LO         32
`define SDRA_ST_STOPL2       6
`define SDRA_ST_STOPL1       5
`define SDRA_ST_VREACH2      4
`define SDRA_ST_VREACH1      3
`define SDRA_ST_DRVERR2      2
`define SDRA_ST_DRVERR1      1
`define SDRA_ST_RESET        0
`define SDRA_RAMP_STOPL_BIT  0
`define SDRA_RAMP_VREACH_BIT 8
`define SDRA_GLOBAL_STATUS_REGISTER_ADDR      7'h01
`define SDRA_RESP_RESET      32'h00000000
`endif

//--- sdra_spi_chk.sv
// port assertions for the serial datagram slave
`timescale 1ns/10ps
module sdra_spi_chk (
  input logic clk,
  input logic reset_n,
  input logic chip_select_low,
  input logic sdo,
  input logic reg_wr_stb,
  input logic reg_rd_stb,
  input logic global_status_register_clr_stb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire stb = reg_wr_stb | reg_rd_stb;
  // two sync flops, edge detect, then the registered strobe
  sequence s_cmd_taken; ##[2:6] stb; endsequence
  // first sck fall is ignored, so the top bit sits there
  sequence s_msb_zero; ##5 (!sdo)[*3]; endsequence
  chk_wr_single: assert property (reg_wr_stb |=> (!reg_wr_stb)[*8])
    else $error("write strobe repeated");
  chk_rd_single: assert property (reg_rd_stb |=> (!reg_rd_stb)[*8])
    else $error("read strobe repeated");
  chk_stb_excl: assert property (!(reg_wr_stb && reg_rd_stb))
    else $error("read and write strobe together");
  chk_clr_with_rd: assert property (global_status_register_clr_stb |-> reg_rd_stb)
    else $error("flag clear without read");
  chk_cmd_taken: assert property ($rose(chip_select_low) |-> s_cmd_taken)
    else $error("no command after frame end");
  chk_stb_cs_high: assert property (stb |-> chip_select_low && $past(chip_select_low))
    else $error("strobe inside a frame");
  chk_sdo_idle: assert property (chip_select_low[*5] |-> $stable(sdo))
    else $error("sdo moved between frames");
  chk_stat_msb: assert property ($fell(chip_select_low) |-> s_msb_zero)
    else $error("status top bit not zero");
endmodule
bind sdra_spi sdra_spi_chk u_chk (.clk(clk), .reset_n(reset_n), .chip_select_low(chip_select_low),
  .sdo(sdo), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .global_status_register_clr_stb(global_status_register_clr_stb));

//--- sdra_master.sv
// spi master model, mode 3, sck only runs inside frames
`timescale 1ns/10ps
module sdra_master (
  output logic sck,
  output logic sdi,
  output logic chip_select_low,
  input  logic sdo
);
  initial begin
    sck             = 1'b1;
    sdi             = 1'b1;
    chip_select_low = 1'b1;
  end
  // 400 ns halves keep sck well under half the system clock
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    chip_select_low = 1'b0;
    #400;
    for (int i = 39; i >= 0; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      #400;
      sck = 1'b1;
      #400;
      rx[i] = sdo;
    end
    #400;
    chip_select_low = 1'b1;
    // released line must not keep the last bit
    sdi = ~sdi;
    #800;
  endtask
endmodule

//--- sdra_spi_test.sv
// self-checking bench for the serial datagram slave
`timescale 1ns/10ps
module sdra_spi_test;
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] ramp1   = 32'h00000001;
  logic [31:0] ramp2   = 32'h00000100;
  logic [2:0]  gs      = 3'b101;
  logic [31:0] mem [0:127];
  logic [39:0] rx;
  int          n_errors  = 0;
  int          tests_run = 0;
  wire         sck, sdi, chip_select_low, sdo, reg_wr_stb, reg_rd_stb, global_status_register_clr_stb;
  wire [6:0]   reg_addr;
  wire [31:0]  reg_wr_data;
  wire [31:0]  rd_data = (reg_addr == 7'h01) ? {29'h0, gs} : mem[reg_addr];
  logic [39:0] tx [0:7] = '{40'h0100000000, 40'hA0DEADBEEF, 40'h2000000000, 40'h8112345678,
    40'h0100000000, 40'h20FFFFFFFF, 40'h2000000000, 40'h0000000000};
  logic [39:0] ex [0:7] = '{40'h0000000000, 40'h3500000005, 40'h48DEADBEEF, 40'h48DEADBEEF,
    40'h4812345678, 40'h4800000000, 40'h48DEADBEEF, 40'h48DEADBEEF};
  always #50 clk = ~clk;
  // register side: address 1 is read-only, its flags clear on read
  always @(posedge clk) begin
    if (reg_wr_stb && reg_addr != 7'h01)
      mem[reg_addr] <= reg_wr_data;
    if (global_status_register_clr_stb)
      gs <= 3'b000;
  end
  sdra_spi DUT (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .sck(sck), .sdi(sdi),
    .chip_select_low(chip_select_low), .sdo(sdo), .axis1_ramp_status(ramp1),
    .axis2_ramp_status(ramp2), .global_status_register(gs), .reg_rd_data(rd_data),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .global_status_register_clr_stb(global_status_register_clr_stb));
  sdra_master u_mst (.sck(sck), .sdi(sdi), .chip_select_low(chip_select_low), .sdo(sdo));
  task check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t reply %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      // new ramp flags land before the second frame ends
      if (i == 1) begin
        ramp1 = 32'h00000100;
        ramp2 = 32'h00000001;
      end
      u_mst.xfer(tx[i], rx);
      check(rx, ex[i]);
    end
    test_done();
  end
endmodule
